// File: rtl/ddri_regs.vh
// constants for the ddr power-up sequencer: command codes, mode fields,
// and wait counts derived from the 50 MHz ref_clk.
// assumes a four-bank ddr part reached only through its command pins.
//
// Behaviour
// - burst access: row_open then read/write
// - 200 us nop with clock enable high
// - close_all_banks then precharge_gap of nops
// - ext_mode_set, mode_set dll reset, gap
// - close_all_banks again, two refresh_cmd
// - final mode_set clears dll reset, gap
// - 200 cycles after dll reset before commands
// - refreshes may follow first mode_set instead
// - mode_set only with all banks idle
// - a7 and up zero, a8 dll reset
// - dll reset mode_set needs normal follow-up
// - no other a7-and-up encodings
// - banks closed before any refresh
`ifndef DDRI_REGS_VH
`define DDRI_REGS_VH

// ***********************************************************
// command encodings {cs_n, ras_n, cas_n, we_n}
// ***********************************************************
`define DDRI_CMD_NOP       4'h7
`define DDRI_CMD_PRE       4'h2
`define DDRI_CMD_REF       4'h1
`define DDRI_CMD_MSET      4'h0

// ***********************************************************
// mode field positions and widths
// ***********************************************************
`define DDRI_BL_LSB        0
`define DDRI_BT_BIT        3
`define DDRI_CL_LSB        4
`define DDRI_DLL_BIT       8
`define DDRI_ACLOSE_BIT    10
`define DDRI_ADDR_W        13
`define DDRI_BL_2          3'h1
`define DDRI_BL_4          3'h2
`define DDRI_BL_8          3'h3
`define DDRI_CL_2          3'h2
`define DDRI_CL_25         3'h6
`define DDRI_CL_3          3'h3
`define DDRI_BANK_BASE     2'h0
`define DDRI_BANK_EXT      2'h1

// ***********************************************************
// timing: figures in own units, counts in ref_clk cycles
// ***********************************************************
`define DDRI_CLK_MHZ       50
`define DDRI_T_PWRUP_US    200
`define DDRI_N_PWRUP       (`DDRI_T_PWRUP_US * `DDRI_CLK_MHZ)
`define DDRI_T_RP_NS       20
`define DDRI_N_RP          ((`DDRI_T_RP_NS * `DDRI_CLK_MHZ + 999) / 1000)
`define DDRI_N_MRD         2
`define DDRI_N_DLL         200
`define DDRI_N_REF         2
`define DDRI_CNT_W         16

`endif

// File: rtl/ddri_init.v
// power-up sequencer that drives a ddr sdram through its command pins
// and programs the extended and base config registers.
// assumes the memory clock is ref_clk itself, driven out by the pad ring.
`timescale 1ns/100ps
`include "ddri_regs.vh"

module ddri_init #(
  parameter PWRUP_CYCLES = `DDRI_N_PWRUP
) (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        start,
  input  wire [2:0]  burst_len,
  input  wire        burst_type,
  input  wire [2:0]  cas_lat,
  input  wire [12:0] ext_mode,
  output reg         mem_cke,
  output reg         mem_cs_n,
  output reg         mem_ras_n,
  output reg         mem_cas_n,
  output reg         mem_we_n,
  output reg  [1:0]  mem_ba,
  output reg  [12:0] mem_addr,
  output reg         busy,
  output reg         init_done
);

  // ***********************************************************
  // states
  // ***********************************************************
  localparam ST_IDLE  = 4'h0;
  localparam ST_PWRUP = 4'h1;
  localparam ST_PRE1  = 4'h2;
  localparam ST_XSET  = 4'h3;
  localparam ST_MSET1 = 4'h4;
  localparam ST_PRE2  = 4'h5;
  localparam ST_REF   = 4'h6;
  localparam ST_MSET2 = 4'h7;
  localparam ST_WAIT  = 4'h8;
  localparam ST_DONE  = 4'h9;

  reg [3:0]             state;
  reg [3:0]             after_wait;
  reg [`DDRI_CNT_W-1:0] wait_cnt;
  reg [7:0]             dll_cnt;
  reg [1:0]             ref_cnt;
  reg [12:0]            op_fields;
  wire                  take_start;

  // ***********************************************************
  // counts and address patterns at their register widths
  // ***********************************************************
  // the header figures are plain integers; they are widened to a
  // known 32 bits first and then cut, so every counter load below
  // is exactly as wide as the counter it loads
  localparam [31:0]            PWRUP_FULL = PWRUP_CYCLES;
  localparam [31:0]            PGAP_FULL  = `DDRI_N_RP;
  localparam [31:0]            MGAP_FULL  = `DDRI_N_MRD;
  localparam [31:0]            DLL_FULL   = `DDRI_N_DLL;
  localparam [31:0]            REF_FULL   = `DDRI_N_REF;
  localparam [`DDRI_CNT_W-1:0] N_PWRUP    = PWRUP_FULL[`DDRI_CNT_W-1:0];
  localparam [`DDRI_CNT_W-1:0] N_PGAP     = PGAP_FULL[`DDRI_CNT_W-1:0];
  localparam [`DDRI_CNT_W-1:0] N_MGAP     = MGAP_FULL[`DDRI_CNT_W-1:0];
  localparam [7:0]             N_DLL      = DLL_FULL[7:0];
  localparam [1:0]             N_REF      = REF_FULL[1:0];
  // close_all_banks needs the auto_close_bit; the dll reset bit rides
  // on the first base mode_set only
  localparam [12:0]            ADDR_ONE   = 13'h0001;
  localparam [12:0]            CLOSE_ALL  = ADDR_ONE << `DDRI_ACLOSE_BIT;
  localparam [12:0]            DLL_RESET  = ADDR_ONE << `DDRI_DLL_BIT;

  // ***********************************************************
  // start acceptance
  // ***********************************************************
  // a start is honoured only with no sequence running; one seen in
  // ST_DONE reruns the whole order, for a part that lost power
  assign take_start = (state == ST_IDLE || state == ST_DONE) && start;

  // ***********************************************************
  // operating fields latched at start
  // ***********************************************************
  // a7 and above stay zero so no reserved mode is ever written
  always @(posedge ref_clk) begin
    if (rst) begin
      op_fields <= 13'h0000;
    end else if (take_start) begin
      op_fields <= 13'h0000;
      op_fields[`DDRI_BL_LSB+2:`DDRI_BL_LSB] <= burst_len;
      op_fields[`DDRI_BT_BIT] <= burst_type;
      op_fields[`DDRI_CL_LSB+2:`DDRI_CL_LSB] <= cas_lat;
    end
  end

  // ***********************************************************
  // dll settle counter
  // ***********************************************************
  // loaded by the dll reset mode_set and run down to zero; it overlaps
  // the close_all_banks and refreshes that follow, so it only costs
  // time when it outlasts the final mode_set gap
  always @(posedge ref_clk) begin
    if (rst) begin
      dll_cnt <= 8'h00;
    end else if (state == ST_MSET1) begin
      dll_cnt <= N_DLL;
    end else if (dll_cnt != 8'h00) begin
      dll_cnt <= dll_cnt - 8'h01;
    end
  end

  // ***********************************************************
  // sequencer
  // ***********************************************************
  // each command lasts one cycle; gaps reuse ST_WAIT with nops
  // order: power-up nops, close_all_banks, ext_mode_set, mode_set
  // with dll reset, close_all_banks, two refresh_cmd, mode_set
  // without it; done waits for both the last gap and the dll count
  always @(posedge ref_clk) begin
    if (rst) begin
      state      <= ST_IDLE;
      after_wait <= ST_IDLE;
      wait_cnt   <= {`DDRI_CNT_W{1'b0}};
      ref_cnt    <= 2'h0;
      mem_cke    <= 1'b0;
      mem_cs_n   <= 1'b1;
      mem_ras_n  <= 1'b1;
      mem_cas_n  <= 1'b1;
      mem_we_n   <= 1'b1;
      mem_ba     <= 2'h0;
      mem_addr   <= 13'h0000;
      busy       <= 1'b0;
      init_done  <= 1'b0;
    end else begin
      // default: nop; only one cycle per real command
      {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= `DDRI_CMD_NOP;
      // no row_open, read or write is ever issued from here, so no
      // burst can start without an open row
      case (state)
        ST_IDLE: begin
          if (start) begin
            busy      <= 1'b1;
            init_done <= 1'b0;
            mem_cke   <= 1'b1;
            wait_cnt  <= N_PWRUP;
            state     <= ST_PWRUP;
          end
        end
        ST_PWRUP: begin
          if (wait_cnt <= 1)
            state <= ST_PRE1;
          else
            wait_cnt <= wait_cnt - 1'b1;
        end
        ST_PRE1: begin
          {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= `DDRI_CMD_PRE;
          mem_addr   <= CLOSE_ALL;
          wait_cnt   <= N_PGAP;
          after_wait <= ST_XSET;
          state      <= ST_WAIT;
        end
        ST_XSET: begin
          {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= `DDRI_CMD_MSET;
          mem_ba     <= `DDRI_BANK_EXT;
          mem_addr   <= ext_mode;
          wait_cnt   <= N_MGAP;
          after_wait <= ST_MSET1;
          state      <= ST_WAIT;
        end
        ST_MSET1: begin
          {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= `DDRI_CMD_MSET;
          mem_ba     <= `DDRI_BANK_BASE;
          mem_addr   <= op_fields | DLL_RESET;
          wait_cnt   <= N_MGAP;
          after_wait <= ST_PRE2;
          state      <= ST_WAIT;
        end
        ST_PRE2: begin
          {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= `DDRI_CMD_PRE;
          mem_addr   <= CLOSE_ALL;
          ref_cnt    <= N_REF;
          wait_cnt   <= N_PGAP;
          after_wait <= ST_REF;
          state      <= ST_WAIT;
        end
        ST_REF: begin
          // refreshes follow the second close_all_banks; the order that
          // puts them after the first mode_set is not used
          // refresh recovery is assumed covered by the precharge gap count
          {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= `DDRI_CMD_REF;
          ref_cnt    <= ref_cnt - 2'h1;
          wait_cnt   <= N_PGAP;
          after_wait <= (ref_cnt == 2'h1) ? ST_MSET2 : ST_REF;
          state      <= ST_WAIT;
        end
        ST_MSET2: begin
          {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= `DDRI_CMD_MSET;
          mem_ba     <= `DDRI_BANK_BASE;
          mem_addr   <= op_fields;
          wait_cnt   <= N_MGAP;
          after_wait <= ST_DONE;
          state      <= ST_WAIT;
        end
        ST_WAIT: begin
          // done is also held back until the dll settle count ends
          if (wait_cnt <= 1 &&
              (after_wait != ST_DONE || dll_cnt == 8'h00))
            state <= after_wait;
          else if (wait_cnt > 1)
            wait_cnt <= wait_cnt - 1'b1;
        end
        ST_DONE: begin
          busy      <= 1'b0;
          init_done <= 1'b1;
          if (start) begin
            init_done <= 1'b0;
            busy      <= 1'b1;
            wait_cnt  <= N_PWRUP;
            state     <= ST_PWRUP;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule

// File: bench/ddri_init_checker.sv
// concurrent checks on the command pins of the ddr power-up sequencer.
// assumes it is bound to ddri_init and sees only its ports.
`timescale 1ns/100ps
module ddri_init_checker #(
  parameter PWRUP = 20
) (
  input wire        ref_clk,
  input wire        rst,
  input wire        start,
  input wire [2:0]  burst_len,
  input wire        burst_type,
  input wire [2:0]  cas_lat,
  input wire        mem_cke,
  input wire        mem_cs_n,
  input wire        mem_ras_n,
  input wire        mem_cas_n,
  input wire        mem_we_n,
  input wire [1:0]  mem_ba,
  input wire [12:0] mem_addr,
  input wire        busy,
  input wire        init_done
);
  wire [3:0]  cmd = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};
  wire        mset = (cmd == 4'h0) && (mem_ba == 2'h0);
  reg  [15:0] cnt;
  reg  [15:0] dll;
  reg  [1:0]  rf;
  reg         ld;
  reg  [6:0]  f;
  // busy cycles, cycles since dll reset, refreshes since close-all
  always @(posedge ref_clk) begin
    cnt <= (rst || !busy) ? 16'h0000 : cnt + 16'h0001;
    if (start && !busy) f <= {cas_lat, burst_type, burst_len};
    if (mset) ld <= mem_addr[8];
    if (mset && mem_addr[8]) dll <= 16'h0000;
    else if (dll != 16'hFFFF) dll <= dll + 16'h0001;
    if (cmd == 4'h2) rf <= 2'h0;
    else if (cmd == 4'h1) rf <= rf + 2'h1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_pwrup_nop: assert property (busy && cnt <= PWRUP |-> cmd == 4'h7)
    else $error("command during power-up wait");
  chk_first_close: assert property (busy && cnt == PWRUP + 1 |->
    cmd == 4'h2 && mem_addr[10]) else $error("no close-all after wait");
  chk_start_cke: assert property (start && !busy |=> busy && mem_cke)
    else $error("start not taken");
  chk_busy_cke: assert property (busy |-> mem_cke)
    else $error("clock enable dropped during init");
  chk_mset_bank: assert property (cmd == 4'h0 |-> mem_ba <= 2'h1)
    else $error("mode set to bad bank");
  chk_mset_high: assert property (mset |-> mem_addr[12:9] == 4'h0
    && !mem_addr[7]) else $error("reserved mode bits set");
  chk_mset_field: assert property (mset |-> mem_addr[6:0] == f)
    else $error("mode fields differ from start");
  chk_mode_gap: assert property (cmd == 4'h0 |=> cmd == 4'h7)
    else $error("no gap after mode set");
  chk_ref_closed: assert property (cmd == 4'h1 |->
    $past(cmd, 2) == 4'h2 || $past(cmd, 2) == 4'h1)
    else $error("refresh without close-all");
  chk_done_seq: assert property ($rose(init_done) |-> !ld
    && dll >= 16'd199 && rf >= 2'h2 && !busy)
    else $error("init ended early");
endmodule

// File: bench/ddri_mem_model.sv
// behavioural ddr device: decodes commands into its config registers.
// assumes commands are sampled on the rising edge of ref_clk.
`timescale 1ns/100ps
module ddri_mem_model (
  input wire        ref_clk,
  input wire        mem_cke,
  input wire        mem_cs_n,
  input wire        mem_ras_n,
  input wire        mem_cas_n,
  input wire        mem_we_n,
  input wire [1:0]  mem_ba,
  input wire [12:0] mem_addr,
  output reg [12:0] base_cfg,
  output reg [12:0] ext_cfg,
  output reg [1:0]  ref_n
);
  // no default contents, so registers stay unknown until written
  always @(posedge ref_clk) begin
    if (mem_cke) begin
      case ({mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n})
        4'h0: if (mem_ba == 2'h0) base_cfg <= mem_addr;
              else if (mem_ba == 2'h1) ext_cfg <= mem_addr;
        4'h2: if (mem_addr[10]) ref_n <= 2'h0;
        4'h1: ref_n <= ref_n + 2'h1;
        default: ;
      endcase
    end
  end
  // top column bit of the byte-wide part bounds every burst block
  localparam COL_MSB = 9;
  // column of access idx: block from the length, wrap or xor by type
  function [COL_MSB:0] burst_col(input [COL_MSB:0] first, input [2:0] idx);
    reg [2:0] m;
    reg [2:0] o;
    begin
      m = (base_cfg[2:0] == 3'h3) ? 3'h7 :
          (base_cfg[2:0] == 3'h2) ? 3'h3 : 3'h1;
      o = base_cfg[3] ? (first[2:0] ^ idx) : (first[2:0] + idx);
      burst_col = {first[COL_MSB:3], (first[2:0] & ~m) | (o & m)};
    end
  endfunction
  // first read data delay in pin beats, two beats to each clock
  function [3:0] read_beats(input [2:0] lat);
    read_beats = (lat == 3'h2) ? 4'h4 : (lat == 3'h6) ? 4'h5 : 4'h6;
  endfunction
endmodule

// File: bench/tb.sv
// testbench for the ddr power-up sequencer with a device model.
// assumes the short power-up count of 20 cycles.
`timescale 1ns/100ps
`include "ddri_regs.vh"
module tb;
  reg         ref_clk = 1'b0;
  reg         rst = 1'b1;
  reg         start = 1'b0;
  reg  [2:0]  burst_len = 3'h0;
  reg         burst_type = 1'b0;
  reg  [2:0]  cas_lat = 3'h0;
  reg  [12:0] ext_mode = 13'h0000;
  wire        cke, cs_n, ras_n, cas_n, we_n, busy, init_done;
  wire [1:0]  ba, ref_n;
  wire [12:0] addr, base_cfg, ext_cfg;
  integer     num_errors = 0;
  integer     tests_run = 0;
  initial forever #10 ref_clk = ~ref_clk;
  ddri_init #(.PWRUP_CYCLES(20)) uut (.ref_clk(ref_clk), .rst(rst),
    .start(start), .burst_len(burst_len), .burst_type(burst_type),
    .cas_lat(cas_lat), .ext_mode(ext_mode), .mem_cke(cke),
    .mem_cs_n(cs_n), .mem_ras_n(ras_n), .mem_cas_n(cas_n),
    .mem_we_n(we_n), .mem_ba(ba), .mem_addr(addr), .busy(busy),
    .init_done(init_done));
  ddri_mem_model u_mem (.ref_clk(ref_clk), .mem_cke(cke),
    .mem_cs_n(cs_n), .mem_ras_n(ras_n), .mem_cas_n(cas_n),
    .mem_we_n(we_n), .mem_ba(ba), .mem_addr(addr), .base_cfg(base_cfg),
    .ext_cfg(ext_cfg), .ref_n(ref_n));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks=%0d errors=%0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // one full init; a refused start with another burst_len lands mid-run
  task run(input [2:0] bl, input bt, input [2:0] cl, input [12:0] em,
    input [9:0] cx, input [3:0] lx);
    integer n;
    begin
      burst_len = bl;
      burst_type = bt;
      cas_lat = cl;
      ext_mode = em;
      start = 1'b1;
      @(negedge ref_clk) start = 1'b0;
      n = 0;
      while (init_done !== 1'b1 && n < 1000) begin
        @(negedge ref_clk) n = n + 1;
        start = (n == 5);
        burst_len = bl ^ {3{n == 5}};
      end
      chk(init_done, 1'b1);
      chk(n >= 220, 1);
      chk(base_cfg, {6'h00, cl, bt, bl});
      chk(ext_cfg, em);
      chk(ref_n, 2'h2);
      chk(u_mem.burst_col(10'h00B, 3'h1), cx);
      chk(u_mem.read_beats(base_cfg[6:4]), lx);
      $display("test done bl=%h bt=%h cl=%h", bl, bt, cl);
    end
  endtask
  initial begin
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    run(`DDRI_BL_2, 1'b0, `DDRI_CL_2, 13'h0002, 10'h00A, 4'h4);
    run(`DDRI_BL_4, 1'b1, `DDRI_CL_25, 13'h0001, 10'h00A, 4'h5);
    start = 1'b1;
    @(negedge ref_clk) start = 1'b0;
    repeat (30) @(negedge ref_clk);
    rst = 1'b1;
    @(negedge ref_clk) chk({cke, busy, init_done, cs_n}, 4'h1);
    $display("test done reset");
    rst = 1'b0;
    run(`DDRI_BL_8, 1'b0, `DDRI_CL_3, 13'h0000, 10'h00C, 4'h6);
    test_done;
  end
  // a hang costs far more than the three full inits of about 230 cycles each and the one cut short by reset
  initial begin
    #200000;
    num_errors = num_errors + 1;
    test_done;
  end
endmodule
bind ddri_init ddri_init_checker #(.PWRUP(PWRUP_CYCLES)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .start(start), .burst_len(burst_len),
  .burst_type(burst_type), .cas_lat(cas_lat), .mem_cke(mem_cke),
  .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n),
  .mem_we_n(mem_we_n), .mem_ba(mem_ba), .mem_addr(mem_addr),
  .busy(busy), .init_done(init_done));
